// *** common/aic_defines.vh ***
// Register map, field layout, reset values and scaling constants of the analog input block
`ifndef AIC_DEFINES_VH
`define AIC_DEFINES_VH
`define AIC_OFF_CONFIG 12'h000
`define AIC_OFF_FUNC 12'h004
`define AIC_OFF_SCALE1 12'h008
`define AIC_OFF_SCALE2 12'h00c
`define AIC_OFF_FILTER 12'h010
`define AIC_OFF_FALLBACK 12'h014
`define AIC_OFF_STATUS 12'h018
`define AIC_OFF_FREQ 12'h01c
`define AIC_CFG_RANGE1 0
`define AIC_CFG_RANGE2 1
`define AIC_CFG_LOSSACT 3
`define AIC_CFG_ENSEL 5
`define AIC_CFG_SRC1 7
`define AIC_CFG_SRC2 11
`define AIC_FN_CH1 0
`define AIC_FN_CH2 8
`define AIC_SC_GAIN 0
`define AIC_SC_BIAS 16
`define AIC_FT_CH1 0
`define AIC_FT_CH2 16
`define AIC_ST_ALARM 0
`define AIC_ST_FAULT 1
`define AIC_ST_LOSS 2
`define AIC_ST_EN1 3
`define AIC_ST_EN2 4
`define AIC_RST_RANGE1 1'b0
`define AIC_RST_RANGE2 2'h1
`define AIC_RST_LOSSACT 2'h0
`define AIC_RST_ENSEL 2'h3
`define AIC_RST_SRC 4'h0
`define AIC_RST_FUNC1 5'h00
`define AIC_RST_FUNC2 5'h08
`define AIC_RST_GAIN 16'h03e8
`define AIC_RST_BIAS 16'h0000
`define AIC_RST_FILT 8'h32
`define AIC_RST_FALLBACK 16'h0000
`define AIC_PCT_MAX 16'h270f
`define AIC_PCT_FULL 16'h03e8
`define AIC_FULL_SHIFT 14
`define AIC_FLOOR_4MA 16'h0ccd
`define AIC_LOSS_LEVEL 16'h0666
`define AIC_FILT_MAX 8'hc8
`define AIC_FILT_STEP_US 40'd10000
`define AIC_SAMPLE_US 1000
`define AIC_FN_MAIN 5'h00
`define AIC_FN_FGAIN 5'h01
`define AIC_FN_MAX 5'h13
`define AIC_FN_COUNT 20
`define AIC_SRC_ANALOG 4'h1
`define AIC_LOSS_IGNORE 2'h0
`define AIC_LOSS_PRESET 2'h1
`define AIC_LOSS_ZERO 2'h2
`define AIC_LOSS_STOP 2'h3
`endif

// *** logic/aic_lag_filter.v ***
// First-order lag filter on one normalized analog channel
`include "aic_defines.vh"
module aic_lag_filter #(
  parameter SAMPLE_US = `AIC_SAMPLE_US
) (
  input wire clk,
  input wire reset,
  input wire inValid,
  input wire [15:0] inValue,
  input wire [7:0] filterTime,
  output wire outValid,
  output wire [15:0] outValue
);
  reg signed [31:0] acc_reg;
  reg outValid_reg;
  // Divider is shared by nothing; the setting changes rarely so its depth is acceptable
  wire [39:0] den = {32'h0, filterTime} * `AIC_FILT_STEP_US + SAMPLE_US;
  wire [39:0] coef = ({24'h0, SAMPLE_US[15:0]} << 16) / den;
  wire signed [32:0] target = {inValue[15], inValue, 16'h0000};
  wire signed [32:0] diff = target - {acc_reg[31], acc_reg};
  wire signed [50:0] step = diff * $signed({1'b0, coef[16:0]});
  assign outValid = outValid_reg;
  assign outValue = acc_reg[31:16];
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_reg <= 32'h0;
      outValid_reg <= 1'b0;
    end else begin
      outValid_reg <= inValid;
      if (inValid) begin
        if (filterTime == 8'h00)
          acc_reg <= target[31:0];
        else
          acc_reg <= acc_reg + step[47:16];
      end
    end
  end
endmodule

// *** logic/aic_scaler.v ***
// Gain and bias scaling of one channel with saturation and unipolar clamp
`include "aic_defines.vh"
module aic_scaler (
  input wire clk,
  input wire reset,
  input wire inValid,
  input wire [15:0] normValue,
  input wire [15:0] gain,
  input wire [15:0] bias,
  input wire clampNeg,
  output wire outValid,
  output wire [15:0] outValue
);
  reg [15:0] value_reg;
  reg outValid_reg;
  reg [15:0] value_next;
  wire signed [31:0] prod = $signed(gain) * $signed(normValue);
  // Bias must be signed too, or the shift turns logical and negative inputs go huge
  wire signed [31:0] sum = (prod >>> `AIC_FULL_SHIFT) + $signed({{16{bias[15]}}, bias});
  wire signed [31:0] pctMax = {16'h0000, `AIC_PCT_MAX};
  assign outValid = outValid_reg;
  assign outValue = value_reg;
  always @* begin
    // Gain is the rise from zero to full scale, bias the value at zero input
    if (sum > pctMax)
      value_next = `AIC_PCT_MAX;
    else if (sum < -pctMax)
      value_next = 16'h0000 - `AIC_PCT_MAX;
    else
      value_next = sum[15:0];
    if (clampNeg && value_next[15])
      value_next = 16'h0000;
  end
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      value_reg <= 16'h0000;
      outValid_reg <= 1'b0;
    end else begin
      outValid_reg <= inValid;
      if (inValid)
        value_reg <= value_next;
    end
  end
endmodule

// *** logic/aic_top.v ***
// Analog input conditioning: range, scaling, filtering, loop loss and function routing
`include "aic_defines.vh"
module aic_top #(
  parameter SAMPLE_US = `AIC_SAMPLE_US
) (
  input wire clk,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire sampleValid,
  input wire [15:0] analogInFirst,
  input wire [15:0] analogInSecond,
  input wire analogEnablePin,
  output wire [`AIC_FN_COUNT*16-1:0] routedValue,
  output wire [`AIC_FN_COUNT-1:0] routedValid,
  output wire [15:0] freqCommand,
  output wire freqCommandValid,
  output wire loopLossAlarm,
  output wire loopLossFault
);
  reg firstRange_reg;
  reg [1:0] secondRange_reg;
  reg [1:0] lossAction_reg;
  reg [1:0] enableSel_reg;
  reg [3:0] srcPrimary_reg;
  reg [3:0] srcSecondary_reg;
  reg [4:0] firstFunc_reg;
  reg [4:0] secondFunc_reg;
  reg [15:0] firstGain_reg;
  reg [15:0] firstBias_reg;
  reg [15:0] secondGain_reg;
  reg [15:0] secondBias_reg;
  reg [7:0] firstFilt_reg;
  reg [7:0] secondFilt_reg;
  reg [15:0] fallback_reg;
  reg hreadyout_reg;
  reg [31:0] hrdata_reg;
  reg wrPending_reg;
  reg [11:0] wrAddr_reg;
  reg enMeta_reg;
  reg enSync_reg;
  reg loss_reg;
  reg alarm_reg;
  reg fault_reg;
  reg [15:0] freq_reg;
  reg freqValid_reg;
  reg [`AIC_FN_COUNT*16-1:0] routed_reg;
  reg [`AIC_FN_COUNT-1:0] routedValid_reg;
  reg [31:0] rdata_next;
  reg [15:0] secondNorm;
  reg signed [31:0] freqWork;

  wire [31:0] normFlat;
  wire [1:0] filtValid;
  wire [31:0] filtFlat;
  wire [1:0] scaledValid;
  wire [31:0] scaledFlat;
  wire [31:0] gainFlat = {secondGain_reg, firstGain_reg};
  wire [31:0] biasFlat = {secondBias_reg, firstBias_reg};
  wire [15:0] filtTimeFlat = {secondFilt_reg, firstFilt_reg};
  wire [1:0] clampFlat;
  wire [9:0] funcFlat = {secondFunc_reg, firstFunc_reg};
  wire [1:0] chanEnable;
  wire addrPhase = hsel & hready & htrans[1];
  wire [11:0] aOff = {haddr[11:2], 2'b00};
  wire wrGo = wrPending_reg & hready;
  wire faultClear = wrGo && (wrAddr_reg == `AIC_OFF_STATUS) && hwdata[`AIC_ST_FAULT];
  wire [15:0] loopOff = analogInSecond - `AIC_FLOOR_4MA;
  wire lossNow = (secondRange_reg == 2'h1) && ($signed(analogInSecond) < $signed(`AIC_LOSS_LEVEL));

  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign routedValue = routed_reg;
  assign routedValid = routedValid_reg;
  assign freqCommand = freq_reg;
  assign freqCommandValid = freqValid_reg;
  assign loopLossAlarm = alarm_reg;
  assign loopLossFault = fault_reg;

  // Enable code only applies while the enable input is asserted
  assign chanEnable = enSync_reg ? enableSel_reg : 2'h3;
  assign clampFlat[0] = ~firstRange_reg;
  assign clampFlat[1] = secondRange_reg[1];
  assign normFlat[15:0] = analogInFirst;

  always @* begin
    // Every range is mapped so its full-scale reads as the same normalized value
    case (secondRange_reg)
      2'h1: secondNorm = loopOff + {{2{loopOff[15]}}, loopOff[15:2]};
      2'h3: secondNorm = {analogInSecond[14:0], 1'b0};
      default: secondNorm = analogInSecond;
    endcase
  end
  assign normFlat[31:16] = secondNorm;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : chan
      aic_lag_filter #(.SAMPLE_US(SAMPLE_US)) filt (
        .clk(clk),
        .reset(reset),
        .inValid(sampleValid),
        .inValue(normFlat[ch*16 +: 16]),
        .filterTime(filtTimeFlat[ch*8 +: 8]),
        .outValid(filtValid[ch]),
        .outValue(filtFlat[ch*16 +: 16])
      );
      aic_scaler scale (
        .clk(clk),
        .reset(reset),
        .inValid(filtValid[ch]),
        .normValue(filtFlat[ch*16 +: 16]),
        .gain(gainFlat[ch*16 +: 16]),
        .bias(biasFlat[ch*16 +: 16]),
        .clampNeg(clampFlat[ch]),
        .outValid(scaledValid[ch]),
        .outValue(scaledFlat[ch*16 +: 16])
      );
    end
  endgenerate

  // Lower channel wins when both pick the same function
  genvar fn;
  generate
    for (fn = 0; fn < `AIC_FN_COUNT; fn = fn + 1) begin : route
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          routed_reg[fn*16 +: 16] <= 16'h0000;
          routedValid_reg[fn] <= 1'b0;
        end else if (scaledValid[0]) begin
          if (chanEnable[0] && firstFunc_reg == fn) begin
            routed_reg[fn*16 +: 16] <= scaledFlat[15:0];
            routedValid_reg[fn] <= 1'b1;
          end else if (chanEnable[1] && secondFunc_reg == fn) begin
            routed_reg[fn*16 +: 16] <= scaledFlat[31:16];
            routedValid_reg[fn] <= 1'b1;
          end else begin
            routed_reg[fn*16 +: 16] <= 16'h0000;
            routedValid_reg[fn] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Frequency command from the scaled channels; the result is clamped to plus or minus full scale
  reg mainHit;
  reg gainHit;
  reg [15:0] mainVal;
  reg [15:0] gainVal;
  integer k;
  always @* begin
    mainHit = 1'b0;
    gainHit = 1'b0;
    mainVal = 16'h0000;
    gainVal = 16'h0000;
    freqWork = 32'sh0;
    for (k = 1; k >= 0; k = k - 1) begin
      if (chanEnable[k] && funcFlat[k*5 +: 5] == `AIC_FN_MAIN &&
          (srcPrimary_reg == `AIC_SRC_ANALOG || srcSecondary_reg == `AIC_SRC_ANALOG)) begin
        mainHit = 1'b1;
        mainVal = scaledFlat[k*16 +: 16];
      end
      if (chanEnable[k] && funcFlat[k*5 +: 5] == `AIC_FN_FGAIN) begin
        gainHit = 1'b1;
        gainVal = scaledFlat[k*16 +: 16];
      end
    end
    freqWork = {{16{mainVal[15]}}, mainVal};
    if (gainHit)
      freqWork = ($signed(mainVal) * $signed(gainVal)) / 32'sd1000;
    if (freqWork > $signed({16'h0000, `AIC_PCT_FULL}))
      freqWork = {16'h0000, `AIC_PCT_FULL};
    else if (freqWork < -$signed({16'h0000, `AIC_PCT_FULL}))
      freqWork = -$signed({16'h0000, `AIC_PCT_FULL});
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      enMeta_reg <= 1'b0;
      enSync_reg <= 1'b0;
    end else begin
      enMeta_reg <= analogEnablePin;
      enSync_reg <= enMeta_reg;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      loss_reg <= 1'b0;
      alarm_reg <= 1'b0;
      fault_reg <= 1'b0;
      freq_reg <= 16'h0000;
      freqValid_reg <= 1'b0;
    end else begin
      if (sampleValid)
        loss_reg <= lossNow;
      alarm_reg <= loss_reg && (lossAction_reg == `AIC_LOSS_PRESET ||
                                lossAction_reg == `AIC_LOSS_ZERO);
      // Set again on every sample while the loss stands, and wins over a clear in the same cycle
      if (filtValid[0] && loss_reg && lossAction_reg == `AIC_LOSS_STOP)
        fault_reg <= 1'b1;
      else if (faultClear)
        fault_reg <= 1'b0;
      freqValid_reg <= scaledValid[0] && (mainHit || loss_reg);
      if (scaledValid[0]) begin
        if (loss_reg && lossAction_reg == `AIC_LOSS_PRESET)
          freq_reg <= fallback_reg;
        else if (loss_reg && lossAction_reg != `AIC_LOSS_IGNORE)
          freq_reg <= 16'h0000;
        else if (mainHit)
          freq_reg <= freqWork[15:0];
        else
          freq_reg <= 16'h0000;
      end
    end
  end

  always @* begin
    case (aOff)
      `AIC_OFF_CONFIG: rdata_next = {17'h0, srcSecondary_reg, srcPrimary_reg, enableSel_reg,
                                     lossAction_reg, secondRange_reg, firstRange_reg};
      `AIC_OFF_FUNC: rdata_next = {19'h0, secondFunc_reg, 3'h0, firstFunc_reg};
      `AIC_OFF_SCALE1: rdata_next = {firstBias_reg, firstGain_reg};
      `AIC_OFF_SCALE2: rdata_next = {secondBias_reg, secondGain_reg};
      `AIC_OFF_FILTER: rdata_next = {8'h0, secondFilt_reg, 8'h0, firstFilt_reg};
      `AIC_OFF_FALLBACK: rdata_next = {16'h0, fallback_reg};
      `AIC_OFF_STATUS: rdata_next = {27'h0, chanEnable, loss_reg, fault_reg, alarm_reg};
      `AIC_OFF_FREQ: rdata_next = {16'h0, freq_reg};
      default: rdata_next = 32'h0;
    endcase
  end

  // Limits checked on write; an out of range field keeps its old value
  wire g1Ok = ($signed(hwdata[15:0]) <= $signed(`AIC_PCT_MAX)) &&
              ($signed(hwdata[15:0]) >= -$signed(`AIC_PCT_MAX));
  wire b1Ok = ($signed(hwdata[31:16]) <= $signed(`AIC_PCT_MAX)) &&
              ($signed(hwdata[31:16]) >= -$signed(`AIC_PCT_MAX));

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0;
      wrPending_reg <= 1'b0;
      wrAddr_reg <= 12'h0;
      firstRange_reg <= `AIC_RST_RANGE1;
      secondRange_reg <= `AIC_RST_RANGE2;
      lossAction_reg <= `AIC_RST_LOSSACT;
      enableSel_reg <= `AIC_RST_ENSEL;
      srcPrimary_reg <= `AIC_RST_SRC;
      srcSecondary_reg <= `AIC_RST_SRC;
      firstFunc_reg <= `AIC_RST_FUNC1;
      secondFunc_reg <= `AIC_RST_FUNC2;
      firstGain_reg <= `AIC_RST_GAIN;
      firstBias_reg <= `AIC_RST_BIAS;
      secondGain_reg <= `AIC_RST_GAIN;
      secondBias_reg <= `AIC_RST_BIAS;
      firstFilt_reg <= `AIC_RST_FILT;
      secondFilt_reg <= `AIC_RST_FILT;
      fallback_reg <= `AIC_RST_FALLBACK;
    end else begin
      hreadyout_reg <= 1'b1;
      if (hready)
        wrPending_reg <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_reg <= aOff;
        hrdata_reg <= rdata_next;
      end
      if (wrGo) begin
        case (wrAddr_reg)
          `AIC_OFF_CONFIG: begin
            firstRange_reg <= hwdata[`AIC_CFG_RANGE1];
            secondRange_reg <= hwdata[`AIC_CFG_RANGE2 +: 2];
            lossAction_reg <= hwdata[`AIC_CFG_LOSSACT +: 2];
            enableSel_reg <= hwdata[`AIC_CFG_ENSEL +: 2];
            srcPrimary_reg <= hwdata[`AIC_CFG_SRC1 +: 4];
            srcSecondary_reg <= hwdata[`AIC_CFG_SRC2 +: 4];
          end
          `AIC_OFF_FUNC: begin
            if (hwdata[`AIC_FN_CH1 +: 5] <= `AIC_FN_MAX)
              firstFunc_reg <= hwdata[`AIC_FN_CH1 +: 5];
            if (hwdata[`AIC_FN_CH2 +: 5] <= `AIC_FN_MAX)
              secondFunc_reg <= hwdata[`AIC_FN_CH2 +: 5];
          end
          `AIC_OFF_SCALE1: begin
            if (g1Ok)
              firstGain_reg <= hwdata[`AIC_SC_GAIN +: 16];
            if (b1Ok)
              firstBias_reg <= hwdata[`AIC_SC_BIAS +: 16];
          end
          `AIC_OFF_SCALE2: begin
            if (g1Ok)
              secondGain_reg <= hwdata[`AIC_SC_GAIN +: 16];
            if (b1Ok)
              secondBias_reg <= hwdata[`AIC_SC_BIAS +: 16];
          end
          `AIC_OFF_FILTER: begin
            if (hwdata[`AIC_FT_CH1 +: 8] <= `AIC_FILT_MAX)
              firstFilt_reg <= hwdata[`AIC_FT_CH1 +: 8];
            if (hwdata[`AIC_FT_CH2 +: 8] <= `AIC_FILT_MAX)
              secondFilt_reg <= hwdata[`AIC_FT_CH2 +: 8];
          end
          `AIC_OFF_FALLBACK: fallback_reg <= hwdata[15:0];
          default: hreadyout_reg <= 1'b1;
        endcase
      end
    end
  end
endmodule

// *** tb/aic_checker_assertions.sv ***
// Port-level concurrent checks for the analog input conditioning block
`include "aic_defines.vh"
module aic_checker (
  input wire clk,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire sampleValid,
  input wire [`AIC_FN_COUNT-1:0] routedValid,
  input wire [15:0] freqCommand,
  input wire freqCommandValid,
  input wire loopLossFault
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire addrPhase = hsel && htrans[1] && hreadyout;
  wire statusWrite = addrPhase && hwrite && haddr[11:2] == 10'h6;
  property p_okay; hresp == 1'b0 && hreadyout == 1'b1; endproperty
  property p_rd_hold; !addrPhase |=> $stable(hrdata); endproperty
  property p_unmapped; addrPhase && !hwrite && haddr[11:2] > 10'h7 |=> hrdata == 32'h0; endproperty
  property p_freq_time; freqCommandValid |-> $past(sampleValid, 3); endproperty
  property p_freq_sat;
    freqCommandValid |-> $signed(freqCommand) <= 1000 && $signed(freqCommand) >= -1000;
  endproperty
  property p_freq_hold; !$past(sampleValid, 3) |-> $stable(freqCommand); endproperty
  property p_route_hold; !$past(sampleValid, 3) |-> $stable(routedValid); endproperty
  property p_fault_set; $rose(loopLossFault) |-> $past(sampleValid, 2); endproperty
  // Sticky fault may only drop two edges after a status write with bit 1 set
  property p_fault_clr; $fell(loopLossFault) |-> $past(statusWrite, 2) && $past(hwdata[1]); endproperty
  a_okay: assert property (p_okay) else $error("bus answer not zero-wait OKAY");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without address phase");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_freq_time: assert property (p_freq_time) else $error("command pulse not 3 after sample");
  a_freq_sat: assert property (p_freq_sat) else $error("command beyond full scale");
  a_freq_hold: assert property (p_freq_hold) else $error("command moved between samples");
  a_route_hold: assert property (p_route_hold) else $error("routing moved between samples");
  a_fault_set: assert property (p_fault_set) else $error("fault rose off sample timing");
  a_fault_clr: assert property (p_fault_clr) else $error("fault dropped without clear");
  c_full: cover property (freqCommandValid && freqCommand == 16'h03e8);
  c_fault: cover property ($rose(loopLossFault));
  c_read: cover property (addrPhase && !hwrite);
endmodule

bind aic_top aic_checker u_aicChecker (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hreadyout, .hresp, .hrdata, .sampleValid, .routedValid, .freqCommand, .freqCommandValid,
  .loopLossFault);

// *** tb/aic_src_model.sv ***
// Converter sample source that feeds both analog channels
module aic_src_model (
  input wire clk,
  output logic sampleValid,
  output logic [15:0] analogInFirst,
  output logic [15:0] analogInSecond
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sampleValid = 1'b0;
    analogInFirst = 16'h0;
    analogInSecond = 16'h0;
  end
  // Data is only good in the strobe cycle; scrambling it after catches late capture
  task automatic send(input [15:0] f, input [15:0] s, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    sampleValid <= 1'b1;
    analogInFirst <= f;
    analogInSecond <= s;
    @(posedge clk);
    sampleValid <= 1'b0;
    analogInFirst <= ~f;
    analogInSecond <= ~s;
  endtask
endmodule

// *** tb/aic_testbench.sv ***
// Self-checking bench for the analog input conditioning block
`include "aic_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, hsel, hwrite, analogEnablePin, rdPhase;
  logic [31:0] haddr, hwdata, seed;
  logic [1:0] htrans;
  wire hready, hreadyout, hresp, freqCommandValid, loopLossAlarm, loopLossFault, sampleValid;
  wire [31:0] hrdata;
  wire [15:0] freqCommand, analogInFirst, analogInSecond;
  wire [`AIC_FN_COUNT*16-1:0] routedValue;
  wire [`AIC_FN_COUNT-1:0] routedValid;
  int errCount, totalChecks, k, a;
  logic [31:0] rdQ[$];
  logic [15:0] fqQ[$];
  assign hready = hreadyout;
  aic_top dut (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .sampleValid, .analogInFirst, .analogInSecond, .analogEnablePin,
    .routedValue, .routedValid, .freqCommand, .freqCommandValid, .loopLossAlarm, .loopLossFault);
  aic_src_model src (.clk, .sampleValid, .analogInFirst, .analogInSecond);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [31:0] cfg(input [3:0] src, input [1:0] ens, act, r2, input r1);
    cfg = {21'h0, src, ens, act, r2, r1};
  endfunction
  task automatic check(input string nm, input [31:0] e, input [31:0] g);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic endOfTest;
    if (errCount == 0 && totalChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic waitReady;
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      errCount++;
      endOfTest;
    end
  endtask
  // For a read, d is the expected word
  task automatic bus(input w, input [31:0] ad, input [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= 2'h2;
    hwrite <= w;
    waitReady;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdPhase <= !w;
    if (!w) rdQ.push_back(d);
    waitReady;
    rdPhase <= 1'b0;
  endtask
  task automatic sample(input [15:0] f, s, e, input bit want, input int w);
    if (want) fqQ.push_back(e);
    src.send(f, s, int'(seed[0]));
    repeat (w) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rdPhase && hreadyout === 1'b1) check("hrdata", rdQ.pop_front(), hrdata);
    if (freqCommandValid === 1'b1) begin
      if (fqQ.size() == 0) check("freqCommand pulse", 32'h0, 32'h1);
      else check("freqCommand", {16'h0, fqQ.pop_front()}, {16'h0, freqCommand});
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    endOfTest;
  end
  initial begin
    reset = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, analogEnablePin, rdPhase} = '0;
    seed = 32'h6c88c3e8;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    bus(0, 32'h0, 32'h0000_0062);
    bus(0, 32'h4, 32'h0000_0800);
    bus(0, 32'h8, 32'h0000_03e8);
    bus(0, 32'hc, 32'h0000_03e8);
    bus(0, 32'h10, 32'h0032_0032);
    bus(0, 32'h40, 32'h0);
    bus(1, 32'h10, 32'h00c8_00c9);
    bus(0, 32'h10, 32'h00c8_0032);
    bus(1, 32'h10, 32'h0);
    bus(1, 32'h8, 32'hff06_2710);
    bus(0, 32'h8, 32'hff06_03e8);
    bus(1, 32'h0, cfg(1, 3, 0, 2, 1));
    sample(16'h0, 16'h4000, 16'hff06, 1, 4);
    bus(1, 32'h0, cfg(1, 3, 0, 2, 0));
    sample(16'h0, 16'h4000, 16'h0, 1, 4);
    bus(1, 32'h0, cfg(0, 3, 0, 2, 0));
    sample(16'h4000, 16'h4000, 16'h0, 0, 4);
    bus(1, 32'h0, cfg(1, 3, 0, 2, 0));
    bus(1, 32'h8, 32'h0000_07d0);
    sample(16'h3000, 16'h0, 16'h03e8, 1, 4);
    bus(1, 32'h8, 32'h0000_03e8);
    // Samples one or two idle cycles apart, from random full-scale fractions
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      a = int'(seed[7:0]) % 9;
      sample(16'(a * 2048), 16'h4000, 16'(a * 125), 1, 0);
    end
    sample(16'h3000, 16'h1000, 16'h02ee, 1, 4);
    check("feedback value", 32'h00fa, {16'h0, routedValue[8*16 +: 16]});
    check("routed valid", 32'h101, {12'h0, routedValid});
    bus(1, 32'h4, 32'h0000_0100);
    sample(16'h3000, 16'h2000, 16'h0177, 1, 4);
    bus(1, 32'h4, 32'h0000_0800);
    bus(1, 32'h0, cfg(1, 1, 0, 2, 0));
    analogEnablePin <= 1'b1;
    sample(16'h3000, 16'h1000, 16'h02ee, 1, 4);
    check("enabled set", 32'h1, {12'h0, routedValid});
    analogEnablePin <= 1'b0;
    bus(1, 32'h14, 32'h12c);
    for (a = 0; a < 4; a++) begin
      bus(1, 32'h0, cfg(1, 3, a[1:0], 1, 0));
      sample(16'h3000, 16'h0, a == 0 ? 16'h02ee : a == 1 ? 16'h012c : 16'h0, 1, 4);
      check("alarm", {31'h0, a == 1 || a == 2}, {31'h0, loopLossAlarm});
    end
    check("fault", 32'h1, {31'h0, loopLossFault});
    bus(1, 32'h18, 32'h2);
    bus(1, 32'h0, cfg(1, 3, 0, 1, 0));
    sample(16'h3000, 16'h4000, 16'h02ee, 1, 4);
    check("fault cleared", 32'h0, {31'h0, loopLossFault});
    bus(1, 32'hc, 32'hff06_03e8);
    bus(1, 32'h0, cfg(1, 3, 0, 3, 0));
    sample(16'h3000, 16'h1000, 16'h02ee, 1, 4);
    check("half range value", 32'h00fa, {16'h0, routedValue[8*16 +: 16]});
    bus(1, 32'h0, cfg(1, 3, 0, 0, 0));
    sample(16'h3000, 16'hf000, 16'h02ee, 1, 4);
    check("unclamped value", 32'hfe0c, {16'h0, routedValue[8*16 +: 16]});
    check("pending commands", 32'h0, fqQ.size());
    endOfTest;
  end
endmodule
